// [hw/lsd_fifo.sv]
// Purpose: Synchronous FIFO with valid/ready on both sides.
// Assumes: One clock; write and read may happen in the same cycle.
// Notes:   Depth must be a power of two.

`timescale 1ns/1ps
`default_nettype none

module lsd_fifo #(
   parameter int W = 22,
   parameter int DEPTH = 16
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [W-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [W-1:0] o_out_data
);
   import lsd_pkg::*;

   localparam int PW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [PW:0] wr;
      logic [PW:0] rd;
   } lsd_fifo_t;

   lsd_fifo_t f_reg;
   lsd_fifo_t f_next;
   logic full;
   logic empty;

   // =====================================================================
   // Flags: the extra pointer bit tells full from empty
   assign empty = (f_reg.wr == f_reg.rd);
   assign full = (f_reg.wr[PW] != f_reg.rd[PW]) &&
                 (f_reg.wr[PW-1:0] == f_reg.rd[PW-1:0]);
   assign o_in_ready = !full;
   assign o_out_valid = !empty;
   assign o_out_data = f_reg.mem[f_reg.rd[PW-1:0]];

   // Pointer and storage update
   always_comb begin
      f_next = f_reg;
      if (i_in_valid && !full) begin
         f_next.mem[f_reg.wr[PW-1:0]] = i_in_data;
         f_next.wr = f_reg.wr + 1'b1;
      end
      if (i_out_ready && !empty) begin
         f_next.rd = f_reg.rd + 1'b1;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         f_reg <= '0;
      end else begin
         f_reg <= f_next;
      end
   end

endmodule : lsd_fifo

`default_nettype wire

// [hw/lsd_pkg.sv]
// Purpose: Shared constants and types of the line array scan core.
// Assumes: Imported by every design file of the scan core.
// Notes:   Pixel count default is the smallest array of the family.

package lsd_pkg;

   // =====================================================================
   // Geometry and data path
   localparam int N_PIXELS = 256;      // Photodiodes per scan
   localparam int ADDR_W = 10;         // Wide enough for 1024 photodiodes
   localparam int DATA_W = 12;         // Video sample width
   localparam int FIFO_DEPTH = 16;     // Words buffered toward the system

   // =====================================================================
   // Scan sequencer states, one-hot
   typedef enum logic [2:0] {
      LSD_IDLE = 3'h1,
      LSD_SCAN = 3'h2,
      LSD_END = 3'h4
   } lsd_scan_t;

endpackage : lsd_pkg

// [hw/lsd_scan_core.sv]
// Purpose: Digital model of a self-scanning photodiode array's scan logic.
// Assumes: Shift clocks and start arrive as pins, sampled on I_LINK_CLOCK,
//          which must be several times faster than the shift clock.
// Notes:   Samples cross to I_CLOCK by toggle handshake, then a FIFO.

`timescale 1ns/1ps
`default_nettype none

module lsd_scan_core #(
   parameter int N_PIXELS = lsd_pkg::N_PIXELS,
   parameter int ADDR_W = lsd_pkg::ADDR_W,
   parameter int DATA_W = lsd_pkg::DATA_W,
   parameter int FIFO_DEPTH = lsd_pkg::FIFO_DEPTH
) (
   input wire logic I_CLOCK,
   input wire logic I_RST,
   input wire logic I_LINK_CLOCK,
   input wire logic I_PHASE1,
   input wire logic I_PHASE2,
   input wire logic I_SCAN_START_PULSE,
   input wire logic [DATA_W-1:0] I_VIDEO,
   output logic O_SCAN_DONE_N,
   output logic O_PIXEL_SEL,
   output logic [ADDR_W-1:0] O_PIXEL_ADDR,
   output logic O_SAMPLE_LOST,
   output logic O_PHASE_FAULT,
   output logic O_VIDEO_VALID,
   input wire logic I_VIDEO_READY,
   output logic [ADDR_W+DATA_W-1:0] O_VIDEO_DATA
);
   import lsd_pkg::*;

   localparam int WW = ADDR_W + DATA_W;
   localparam logic [ADDR_W-1:0] LAST_ADDR = ADDR_W'(N_PIXELS - 1);

   // =====================================================================
   // Link domain state
   typedef struct packed {
      logic ph1_s1;
      logic ph1_s2;
      logic ph2_s1;
      logic ph2_s2;
      logic ph2_d;
      logic st_s1;
      logic st_s2;
      logic [DATA_W-1:0] vid_s1;
      logic [DATA_W-1:0] vid_s2;
      lsd_scan_t st;
      logic [ADDR_W-1:0] addr;
      logic req;
      logic [WW-1:0] data;
      logic ack_s1;
      logic ack_s2;
      logic done_n;
      logic lost;
      logic fault;
   } lsd_link_t;

   // System domain state
   typedef struct packed {
      logic req_s1;
      logic req_s2;
      logic req_d;
      logic ack;
      logic pend_v;
      logic [WW-1:0] pend;
   } lsd_sys_t;

   lsd_link_t l_reg;
   lsd_link_t l_next;
   lsd_sys_t s_reg;
   lsd_sys_t s_next;
   logic ph2_rise;
   logic ph2_fall;
   logic busy;
   logic load;
   logic fifo_ready;

   // =====================================================================
   // Edge detection on the synchronised phase two, never on the first flop
   assign ph2_rise = l_reg.ph2_s2 && !l_reg.ph2_d;
   assign ph2_fall = !l_reg.ph2_s2 && l_reg.ph2_d;
   assign busy = (l_reg.req != l_reg.ack_s2);
   // The single phase-two fall inside the start pulse loads the register
   assign load = l_reg.st_s2 && ph2_fall;

   // Link outputs come straight from flops, except pixel select, which is decoded from the state
   assign O_SCAN_DONE_N = l_reg.done_n;
   assign O_PIXEL_SEL = (l_reg.st == LSD_SCAN);
   assign O_PIXEL_ADDR = l_reg.addr;
   assign O_SAMPLE_LOST = l_reg.lost;
   assign O_PHASE_FAULT = l_reg.fault;

   // Scan sequencer on the link clock
   always_comb begin
      l_next = l_reg;
      l_next.ph1_s1 = I_PHASE1;
      l_next.ph1_s2 = l_reg.ph1_s1;
      l_next.ph2_s1 = I_PHASE2;
      l_next.ph2_s2 = l_reg.ph2_s1;
      l_next.ph2_d = l_reg.ph2_s2;
      l_next.st_s1 = I_SCAN_START_PULSE;
      l_next.st_s2 = l_reg.st_s1;
      l_next.vid_s1 = I_VIDEO;
      l_next.vid_s2 = l_reg.vid_s1;
      l_next.ack_s1 = s_reg.ack;
      l_next.ack_s2 = l_reg.ack_s1;
      // Overlap is the driver's fault; flagged sticky so software sees it
      if (l_reg.ph1_s2 && l_reg.ph2_s2) begin
         l_next.fault = 1'b1;
      end
      case (l_reg.st)
         LSD_IDLE: begin
            if (load) begin
               l_next.st = LSD_SCAN;
               l_next.addr = '0;
            end
         end
         LSD_SCAN: begin
            if (ph2_rise) begin
               // Slow handshake means a lost sample, not a stall of pins
               if (busy) begin
                  l_next.lost = 1'b1;
               end else begin
                  l_next.data = {l_reg.addr, l_reg.vid_s2};
                  l_next.req = !l_reg.req;
               end
            end
            if (load) begin
               l_next.addr = '0;
            end else if (ph2_fall) begin
               if (l_reg.addr == LAST_ADDR) begin
                  l_next.st = LSD_END;
               end else begin
                  l_next.addr = l_reg.addr + 1'b1;
               end
            end
         end
         LSD_END: begin
            if (ph2_rise) begin
               l_next.done_n = 1'b0;
            end
            if (ph2_fall) begin
               l_next.done_n = 1'b1;
               l_next.st = load ? LSD_SCAN : LSD_IDLE;
               l_next.addr = '0;
            end
         end
         default: begin
            l_next.st = LSD_IDLE;
         end
      endcase
   end

   always_ff @(posedge I_LINK_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         l_reg <= '0;
         l_reg.st <= LSD_IDLE;
         l_reg.done_n <= 1'b1;
      end else begin
         l_reg <= l_next;
      end
   end

   // =====================================================================
   // System side: take a word on a request toggle, hold it until the FIFO
   // accepts; the ack is held back, so the link side drops samples and flags them lost
   always_comb begin
      s_next = s_reg;
      s_next.req_s1 = l_reg.req;
      s_next.req_s2 = s_reg.req_s1;
      if (s_reg.pend_v && fifo_ready) begin
         s_next.pend_v = 1'b0;
      end
      if ((s_reg.req_s2 != s_reg.req_d) && !s_reg.pend_v) begin
         s_next.pend = l_reg.data;
         s_next.pend_v = 1'b1;
         s_next.req_d = s_reg.req_s2;
         s_next.ack = s_reg.req_s2;
      end
   end

   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // Sample buffer toward the consumer
   lsd_fifo #(
      .W(WW),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .i_clk(I_CLOCK),
      .i_rst(I_RST),
      .i_in_valid(s_reg.pend_v),
      .o_in_ready(fifo_ready),
      .i_in_data(s_reg.pend),
      .o_out_valid(O_VIDEO_VALID),
      .i_out_ready(I_VIDEO_READY),
      .o_out_data(O_VIDEO_DATA)
   );

   // =====================================================================
   // Checks on the link clock
   scan_load_a: assert property (
      @(posedge I_LINK_CLOCK) disable iff (I_RST)
      (l_reg.st == LSD_IDLE && load) |=>
         (l_reg.st == LSD_SCAN && l_reg.addr == '0))
      else $error("start did not load the scan");

   sample_take_a: assert property (
      @(posedge I_LINK_CLOCK) disable iff (I_RST)
      (l_reg.st == LSD_SCAN && ph2_rise && !busy) |=>
         (l_reg.req != $past(l_reg.req) &&
          l_reg.data == {$past(l_reg.addr), $past(l_reg.vid_s2)}))
      else $error("sample not taken on phase two rise");

   select_scan_a: assert property (
      @(posedge I_LINK_CLOCK) disable iff (I_RST)
      O_PIXEL_SEL |-> (l_reg.addr <= LAST_ADDR && l_reg.done_n))
      else $error("pixel selected outside scan");

   addr_step_a: assert property (
      @(posedge I_LINK_CLOCK) disable iff (I_RST)
      (l_reg.st == LSD_SCAN && ph2_fall && !load &&
       l_reg.addr != LAST_ADDR) |=> (l_reg.addr == $past(l_reg.addr) + 1'b1))
      else $error("address did not step");

   done_low_a: assert property (
      @(posedge I_LINK_CLOCK) disable iff (I_RST)
      (l_reg.st == LSD_END && ph2_rise) |=> !O_SCAN_DONE_N)
      else $error("done pulse missing after last pixel");

   done_only_end_a: assert property (
      @(posedge I_LINK_CLOCK) disable iff (I_RST)
      $fell(O_SCAN_DONE_N) |-> ($past(l_reg.st) == LSD_END))
      else $error("done pulse outside end of scan");

endmodule : lsd_scan_core

`default_nettype wire

// [verif/lsd_drv_model.sv]
// Purpose: Behavioural start and shift clock driver for the scan core.
// Assumes: Ideal edges; widths in ns come from parameters.
// Notes:   Phases overlap only when the bench asks for it.
`timescale 1ns/1ps
`default_nettype none
module lsd_drv_model #(
   parameter int N_PIX = 20,
   parameter int HI_NS = 320,
   parameter int GAP_NS = 64
) (
   input wire logic i_go,
   input wire logic i_overlap,
   input wire logic i_restart,
   output logic o_phase1,
   output logic o_phase2,
   output logic o_start,
   output logic o_amp_rst,
   output logic [lsd_pkg::DATA_W-1:0] o_video,
   output logic o_busy
);
   // =====
   // One frame per request, one extra pulse for the done strobe
   initial begin
      {o_phase1, o_phase2, o_start, o_busy, o_amp_rst} = 5'h00;
      o_video = 12'hFFF;
      forever begin
         wait (i_go);
         o_busy = 1'b1;
         o_start = 1'b1;
         o_phase2 = 1'b1;
         #(HI_NS) o_phase2 = 1'b0;
         #(GAP_NS) o_start = 1'b0;
         for (int k = 0; k <= N_PIX; k++) begin
            o_video = 12'hA50 ^ 12'(k);
            o_phase1 = 1'b1;
            // Amplifier reset rises a full gap after the last phase-two fall
            o_amp_rst = 1'b1;
            #(HI_NS);
            o_amp_rst = 1'b0;
            if (!(i_overlap && k == N_PIX)) o_phase1 = 1'b0;
            #(GAP_NS) o_phase2 = 1'b1;
            // Restart case: a start pulse around one fall in mid-scan
            if (i_restart && k == N_PIX / 2) o_start = 1'b1;
            #(HI_NS) o_phase2 = 1'b0;
            o_phase1 = 1'b0;
            #(GAP_NS) o_start = 1'b0;
         end
         // Idle video must not look like a held sample
         o_video = ~o_video;
         o_busy = 1'b0;
      end
   end
endmodule : lsd_drv_model
`default_nettype wire

// [verif/tb_top.sv]
// Purpose: Self-checking bench for the scan core.
// Assumes: Short array of 20 pixels keeps the run brief.
// Notes:   Words are collected at the FIFO side and judged per scenario.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import lsd_pkg::*;
   localparam int NPX = 20;
   logic clk = 1'b0, lclk = 1'b0, rst = 1'b1, ready = 1'b0;
   logic go = 1'b0, ovl = 1'b0, rest = 1'b0;
   logic p1, p2, st, amp, done_n, sel, lost, fault, vvalid, busy;
   logic [DATA_W-1:0] video;
   logic [ADDR_W-1:0] addr;
   logic [ADDR_W+DATA_W-1:0] vdata;
   logic [ADDR_W+DATA_W-1:0] got[$];
   int n_mismatch = 0, checks_done = 0, n_done = 0, n_amp = 0;
   // =====
   // Clocks, link clock unrelated in phase
   always #2 clk = ~clk;
   initial #13 forever #32 lclk = ~lclk;
   lsd_drv_model #(.N_PIX(NPX)) u_drv (.i_go(go), .i_overlap(ovl),
      .i_restart(rest), .o_phase1(p1), .o_phase2(p2), .o_start(st),
      .o_amp_rst(amp), .o_video(video), .o_busy(busy));
   lsd_scan_core #(.N_PIXELS(NPX)) u_dut (.I_CLOCK(clk), .I_RST(rst),
      .I_LINK_CLOCK(lclk), .I_PHASE1(p1), .I_PHASE2(p2),
      .I_SCAN_START_PULSE(st), .I_VIDEO(video), .O_SCAN_DONE_N(done_n),
      .O_PIXEL_SEL(sel), .O_PIXEL_ADDR(addr), .O_SAMPLE_LOST(lost),
      .O_PHASE_FAULT(fault), .O_VIDEO_VALID(vvalid),
      .I_VIDEO_READY(ready), .O_VIDEO_DATA(vdata));
   // Consumer side: record every popped word and done strobes
   always @(posedge clk) begin
      if (vvalid === 1'b1 && ready === 1'b1) got.push_back(vdata);
      if ($fell(done_n)) n_done++;
      if ($rose(amp)) n_amp++;
   end
   task automatic check(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch at %0t: got %0h expected %0h", $time, g, e);
      end
   endtask : check
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : report_and_stop
   task automatic run_frame();
      got.delete();
      n_done = 0;
      n_amp = 0;
      // Pins stay quiet until a link edge has passed after any reset
      @(posedge lclk);
      @(posedge clk) #1 go = 1'b1;
      wait (busy === 1'b1);
      @(posedge clk) #1 go = 1'b0;
      wait (busy === 1'b0);
      repeat (100) @(posedge clk);
   endtask : run_frame
   // =====
   // Scenarios
   task automatic t_reset_values();
      check({done_n, sel, lost, fault, vvalid}, 32'h10);
      check(addr, 32'h0);
   endtask : t_reset_values
   task automatic t_full_scan();
      @(posedge clk) #1 ready = 1'b1;
      // Watch the selection open at zero and close on the last pixel
      fork
         run_frame();
         begin
            @(posedge sel) #1 check(addr, 32'h0);
            @(negedge done_n) #1 check({sel, addr}, 32'(NPX - 1));
         end
      join
      check(got.size(), NPX);
      foreach (got[k]) check(got[k], {10'(k), 12'hA50 ^ 12'(k)});
      check(n_done, 1);
      check({sel, lost, fault}, 32'h0);
      check(n_amp, NPX + 1);
   endtask : t_full_scan
   // Consumer stalls the whole frame, so the FIFO fills and refuses
   task automatic t_stall();
      @(posedge clk) #1 ready = 1'b0;
      run_frame();
      @(posedge clk) #1 ready = 1'b1;
      repeat (60) @(posedge clk);
      // Full FIFO, one word held at the crossing, one waiting on the link
      check(got.size(), FIFO_DEPTH + 2);
      foreach (got[k]) check(got[k], {10'(k), 12'hA50 ^ 12'(k)});
      check(lost, got.size() < NPX);
      check(n_done, 1);
   endtask : t_stall
   task automatic t_fault();
      @(posedge clk) #1 ovl = 1'b1;
      run_frame();
      @(posedge clk) #1 ovl = 1'b0;
      check(fault, 32'h1);
      check(n_done, 1);
      check(got.size(), NPX);
      @(posedge clk) #1 rst = 1'b1;
      repeat (3) @(posedge lclk);
      @(posedge clk) #1 rst = 1'b0;
      t_reset_values();
   endtask : t_fault
   // A second start in mid-scan reloads address zero; no done pulse follows
   task automatic t_restart();
      int a;
      @(posedge clk) #1 rest = 1'b1;
      run_frame();
      @(posedge clk) #1 rest = 1'b0;
      check(got.size(), NPX + 1);
      foreach (got[k]) begin
         a = (k <= NPX / 2) ? k : k - NPX / 2 - 1;
         check(got[k], {10'(a), 12'hA50 ^ 12'(k)});
      end
      check({sel, addr}, {21'h0, 1'b1, 10'(NPX / 2)});
      check(n_done, 0);
      check({lost, fault}, 32'h0);
   endtask : t_restart
   // =====
   // Main sequence; reset spans three link edges for both domains
   initial begin
      repeat (3) @(posedge lclk);
      @(posedge clk) #1 rst = 1'b0;
      t_reset_values();
      t_full_scan();
      t_stall();
      t_fault();
      t_restart();
      report_and_stop();
   end
   // Four frames take about 70 us; about three times that is a hang
   initial begin
      #200000;
      n_mismatch++;
      report_and_stop();
   end
endmodule : tb_top
`default_nettype wire
